/* File: include/pac_pkg.sv */
// Purpose: Shared constants and types of the panel adjust and display mode block
// Assumes: APB byte address is four times the register index
// Notes:   One pixel per clk_sys cycle on the display side
package pac_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] PAC_IDX_HADJ  = 8'h23;
  localparam logic [7:0] PAC_IDX_MODE  = 8'h24;
  localparam logic [7:0] PAC_IDX_CTRL  = 8'h30;
  localparam logic [7:0] PAC_IDX_STAT  = 8'h31;
  localparam logic [9:0] PAC_ADDR_HADJ = {PAC_IDX_HADJ, 2'b00};
  localparam logic [9:0] PAC_ADDR_MODE = {PAC_IDX_MODE, 2'b00};
  localparam logic [9:0] PAC_ADDR_CTRL = {PAC_IDX_CTRL, 2'b00};
  localparam logic [9:0] PAC_ADDR_STAT = {PAC_IDX_STAT, 2'b00};
  // Adjust register fields
  localparam int PAC_HADJ_SCT = 7;
  localparam int PAC_HADJ_SCU = 6;
  // Mode register fields
  localparam int PAC_MODE_MON = 7;
  localparam int PAC_MODE_ULE = 6;
  localparam int PAC_MODE_GRM_HI = 5;
  localparam int PAC_MODE_GRM_LO = 3;
  localparam int PAC_MODE_FON_HI = 2;
  // Own control register fields
  localparam int PAC_CTRL_GFX  = 0;
  localparam int PAC_CTRL_LRES = 1;
  localparam int PAC_CTRL_ELP  = 2;
  // Reset values
  localparam logic [7:0] PAC_HADJ_RST    = 8'h00;
  localparam logic [7:0] PAC_MODE_RST_LO = 8'h02;
  localparam logic [7:0] PAC_MODE_RST_HI = 8'hE3;
  localparam logic [7:0] PAC_CTRL_RST    = 8'h00;
  // Counts
  localparam logic [3:0]  PAC_KANJI_UNIT = 4'h8;
  localparam logic [6:0]  PAC_HADJ_FULL  = 7'h40;
  localparam logic [14:0] PAC_BANK_BYTES = 15'h2000;
  // Font width codes
  localparam logic [2:0] PAC_FON_K8  = 3'h5;
  localparam logic [2:0] PAC_FON_K16 = 3'h6;
  // Horizontal adjust sequencer
  typedef enum logic [2:0] {
    PAC_IDLE  = 3'b001,
    PAC_DELAY = 3'b010,
    PAC_LINE  = 3'b100
  } pac_st_e;
endpackage : pac_pkg

/* File: verilog/pac_adjust_mode.sv */
// Purpose: Panel horizontal adjust, CPU access wait, cursor blink and display mode logic
// Assumes: Inputs synchronous to clk_sys; one pixel per clock
// Notes:   Registers reached over APB; answer in second access cycle
`timescale 1ns/10ps
// Behaviour
// R1: Delay panel line start by adjust pixels after hsync rising edge.
// R2: Adjust unit is font width in text, eight in kanji and graphics.
// R3: Adjust moves line latch for LCD, hsync for EL or plasma.
// R4: Adjust covers 8 to 512 pixels at eight-pixel unit.
// R5: Software keeps 2M - ND/8 - alpha at least H + HA.
// R6: Software uses alpha 12 for dual-drive LCD, 9 otherwise.
// R7: Low resolution doubles M and H and lowers alpha by one.
// R8: Hold CPU in wait through memory ready until access served.
// R9: Access timing bit set selects faster CPU access slots.
// R10: Slow blink bit gives 32-field cycle, one on to three off.
// R11: Mode register resets to 02h or E3h by strap.
// R12: Single-tone map: black/black, reverse, or white on black.
// R13: Intensity bits pass unchanged beside colour mapping.
// R14: Underline enable with blue foreground shows underline rows.
// R15: Without single-tone map, underlined blue foreground shows white.
// R16: Depth bits choose bytes per fetch and bits per pixel.
// R17: Bank bit picks two banks by bit 0, four by bits 1..0.
// R18: Four-bank line modulo four picks consecutive 8K blocks.
// R19: Font bits choose 6..10 pixels, 8xN or 16xN kanji.
// R20: Software clears resolution bit for 16-multiple font widths.
// R21: Kanji fetches one character code per eight-pixel unit.
// R22: Software keeps low depth bit zero for non-kanji fonts.
// R23: Reset clears access timing and slow blink bits.
module pac_adjust_mode (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [9:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     raster_addr_bit4_strap,
  input  wire logic                     hsyncN,
  input  wire logic                     displayEn,
  input  wire logic                     cpuMemReq,
  input  wire logic                     cpuSlotStd,
  input  wire logic                     cpuSlotFast,
  input  wire logic                     fieldStart,
  input  wire logic                     cursorBlinkCtrl,
  input  wire logic [3:0]               attrFg,
  input  wire logic [3:0]               attrBg,
  input  wire logic                     underlineRow,
  input  wire logic                     raster_addr_bit0,
  input  wire logic                     raster_addr_bit1,
  output logic                          panel_line_latch,
  output logic                          panelHsyncN,
  output logic                          charFetch,
  output logic                          cpu_memory_ready,
  output logic                          cpuAccessGo,
  output logic                          cursorVisible,
  output logic      [3:0]               pixFg,
  output logic      [3:0]               pixBg,
  output logic                          underlineOn,
  output logic      [14:0]              bankBase,
  output logic      [2:0]               bytesPerFetch,
  output logic      [3:0]               bitsPerPixel,
  output logic      [4:0]               glyphWidth,
  output logic                          kanjiMode
);
  import pac_pkg::*;

  typedef struct packed {
    pac_st_e     st;
    logic [9:0]  delayCnt;
    logic [3:0]  unitCnt;
    logic        hsyncPrev;
    logic        reqPrev;
    logic [7:0]  hadj;
    logic [7:0]  mode;
    logic [7:0]  ctrl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lineLatch;
    logic        hsyncOutN;
    logic        charFetch;
    logic        memReady;
    logic        accessGo;
    logic [4:0]  fieldCnt;
    logic        cursorVisible;
    logic [3:0]  pixFg;
    logic [3:0]  pixBg;
    logic        underlineOn;
    logic [14:0] bankBase;
    logic [2:0]  bytesPerFetch;
    logic [3:0]  bitsPerPixel;
    logic [4:0]  glyphWidth;
    logic        kanjiMode;
  } pac_state_s;

  pac_state_s stateFf;
  pac_state_s nxtState;

  // Text glyph width in pixels; eight for reserved code
  function automatic logic [4:0] glyphPixels(input logic [2:0] glyph_width_sel);
    unique case (glyph_width_sel)
      3'h0:    glyphPixels = 5'd6;
      3'h1:    glyphPixels = 5'd7;
      3'h2:    glyphPixels = 5'd8;
      3'h3:    glyphPixels = 5'd9;
      3'h4:    glyphPixels = 5'd10;
      3'h5:    glyphPixels = 5'd8;
      3'h6:    glyphPixels = 5'd16;
      default: glyphPixels = 5'd8;
    endcase
  endfunction : glyphPixels

  // Pixels per adjust and fetch unit
  function automatic logic [3:0] unitPixels(input logic gfx, input logic [2:0] glyph_width_sel);
    if (gfx || glyph_width_sel == PAC_FON_K8 || glyph_width_sel == PAC_FON_K16) begin
      unitPixels = PAC_KANJI_UNIT;
    end else begin
      unitPixels = 4'(glyphPixels(glyph_width_sel)); // Text widths stay at ten or below
    end
  endfunction : unitPixels

  logic [2:0] fonSel;
  logic [2:0] grmSel;
  logic [3:0] unitNow;
  logic [6:0] adjUnits;
  logic       hsyncRise;
  logic       slotHit;
  logic       apbAccess;
  logic       apbDone;
  logic       addrOk;
  logic [2:0] fgRgb;
  logic [2:0] bgRgb;
  logic       ulShow;

  assign fonSel    = stateFf.mode[PAC_MODE_FON_HI:0];
  assign grmSel    = stateFf.mode[PAC_MODE_GRM_HI:PAC_MODE_GRM_LO];
  assign unitNow   = unitPixels(stateFf.ctrl[PAC_CTRL_GFX], fonSel);
  // Zero field means the full 64-unit span
  assign adjUnits  = (stateFf.hadj[5:0] == 6'h00) ? PAC_HADJ_FULL : {1'b0, stateFf.hadj[5:0]};
  assign hsyncRise = hsyncN && !stateFf.hsyncPrev;
  assign apbAccess = psel && penable;
  assign apbDone   = apbAccess && stateFf.pready;
  assign addrOk    = (paddr == PAC_ADDR_HADJ) || (paddr == PAC_ADDR_MODE) ||
                     (paddr == PAC_ADDR_CTRL) || (paddr == PAC_ADDR_STAT);
  // Fast timing adds the extra slots to the standard ones
  assign slotHit   = cpuSlotStd || (stateFf.hadj[PAC_HADJ_SCT] && cpuSlotFast); // R9
  assign fgRgb     = attrFg[2:0];
  assign bgRgb     = attrBg[2:0];
  assign ulShow    = stateFf.mode[PAC_MODE_ULE] && (fgRgb == 3'h1) && underlineRow; // R14

  // Next state of everything
  always_comb begin
    nxtState = stateFf;
    nxtState.hsyncPrev = hsyncN;
    nxtState.reqPrev   = cpuMemReq;
    nxtState.lineLatch = 1'b0;
    nxtState.hsyncOutN = 1'b1;
    nxtState.charFetch = 1'b0;
    nxtState.accessGo  = 1'b0;
    nxtState.pready    = 1'b0;
    nxtState.pslverr   = 1'b0;

    // APB slave: ready in the second access cycle, write takes effect with it
    if (apbAccess && !stateFf.pready) begin
      nxtState.pready  = 1'b1;
      nxtState.pslverr = !addrOk;
      nxtState.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          paddr == PAC_ADDR_HADJ: nxtState.prdata = {24'h00_0000, stateFf.hadj};
          paddr == PAC_ADDR_MODE: nxtState.prdata = {24'h00_0000, stateFf.mode};
          paddr == PAC_ADDR_CTRL: nxtState.prdata = {29'h0000_0000, stateFf.ctrl[2:0]};
          paddr == PAC_ADDR_STAT: nxtState.prdata = {28'h000_0000, stateFf.kanjiMode,
                                                     stateFf.cursorVisible, !stateFf.memReady,
                                                     stateFf.st == PAC_LINE};
          default:                nxtState.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (apbDone && pwrite) begin
      if (paddr == PAC_ADDR_HADJ) begin
        nxtState.hadj = pwdata[7:0];
      end
      if (paddr == PAC_ADDR_MODE) begin
        nxtState.mode = pwdata[7:0];
      end
      if (paddr == PAC_ADDR_CTRL) begin
        nxtState.ctrl = {5'h00, pwdata[2:0]};
      end
    end

    // Horizontal adjust: count from hsync rising edge, then mark line start
    unique case (stateFf.st)
      PAC_IDLE: begin
        if (hsyncRise) begin
          nxtState.st       = PAC_DELAY;
          nxtState.delayCnt = 10'(adjUnits * unitNow) - 10'd1; // R1 R2 R4
        end
      end
      PAC_DELAY: begin
        if (stateFf.delayCnt == 10'd0) begin
          nxtState.st      = PAC_LINE;
          nxtState.unitCnt = 4'd0;
          if (stateFf.ctrl[PAC_CTRL_ELP]) begin
            nxtState.hsyncOutN = 1'b0; // R3
          end else begin
            nxtState.lineLatch = 1'b1; // R3
          end
        end else begin
          nxtState.delayCnt = stateFf.delayCnt - 10'd1;
        end
      end
      PAC_LINE: begin
        // One code fetch per unit; kanji units are eight pixels wide
        if (displayEn) begin
          if (stateFf.unitCnt == 4'd0) begin
            nxtState.charFetch = 1'b1; // R21
            nxtState.unitCnt   = unitNow - 4'd1;
          end else begin
            nxtState.unitCnt = stateFf.unitCnt - 4'd1;
          end
        end
        if (hsyncRise) begin
          nxtState.st       = PAC_DELAY;
          nxtState.delayCnt = 10'(adjUnits * unitNow) - 10'd1; // R1
        end
      end
      default: nxtState.st = PAC_IDLE;
    endcase

    // CPU wait: ready drops while a request is pending, rises when served
    if (!cpuMemReq) begin
      nxtState.memReady = 1'b1;
    end else if (!stateFf.memReady && slotHit) begin
      nxtState.memReady = 1'b1; // R8
      nxtState.accessGo = 1'b1;
    end else if (stateFf.memReady && !stateFf.accessGo && !stateFf.reqPrev) begin
      nxtState.memReady = 1'b0; // R8
    end

    // Cursor blink from a field counter
    if (fieldStart) begin
      nxtState.fieldCnt = stateFf.fieldCnt + 5'd1;
    end
    if (stateFf.hadj[PAC_HADJ_SCU]) begin
      nxtState.cursorVisible = (stateFf.fieldCnt[4:3] == 2'b00); // R10
    end else if (cursorBlinkCtrl) begin
      nxtState.cursorVisible = !stateFf.fieldCnt[3];
    end else begin
      nxtState.cursorVisible = 1'b1;
    end

    // Attribute colour path; intensity bits bypass the mapping
    nxtState.pixFg = {attrFg[3], fgRgb}; // R13
    nxtState.pixBg = {attrBg[3], bgRgb}; // R13
    if (stateFf.mode[PAC_MODE_MON]) begin
      if (bgRgb == 3'h0 && fgRgb == 3'h0) begin
        nxtState.pixFg[2:0] = 3'h0; // R12
        nxtState.pixBg[2:0] = 3'h0;
      end else if (bgRgb == 3'h7 && fgRgb == 3'h0) begin
        nxtState.pixFg[2:0] = 3'h0; // R12
        nxtState.pixBg[2:0] = 3'h7;
      end else begin
        nxtState.pixFg[2:0] = 3'h7; // R12
        nxtState.pixBg[2:0] = 3'h0;
      end
    end else if (ulShow) begin
      nxtState.pixFg[2:0] = 3'h7; // R15
    end
    nxtState.underlineOn = ulShow; // R14

    // Bank base from raster address; 8K blocks in line order
    if (grmSel[2]) begin
      nxtState.bankBase = 15'({raster_addr_bit1, raster_addr_bit0}) * PAC_BANK_BYTES; // R17 R18
    end else begin
      nxtState.bankBase = raster_addr_bit0 ? PAC_BANK_BYTES : 15'h0000; // R17
    end

    // Graphics depth; bits per pixel doubles at low resolution
    unique case (grmSel[1:0])
      2'b00: begin nxtState.bytesPerFetch = 3'd1; nxtState.bitsPerPixel = 4'd1; end // R16
      2'b01: begin nxtState.bytesPerFetch = 3'd2; nxtState.bitsPerPixel = 4'd2; end // R16
      2'b10: begin nxtState.bytesPerFetch = 3'd4; nxtState.bitsPerPixel = 4'd4; end // R16
      2'b11: begin nxtState.bytesPerFetch = 3'd1; nxtState.bitsPerPixel = 4'd2; end // R16
    endcase
    if (stateFf.ctrl[PAC_CTRL_LRES]) begin
      nxtState.bitsPerPixel = nxtState.bitsPerPixel << 1;
    end

    // Glyph width and kanji flag
    nxtState.glyphWidth = glyphPixels(fonSel); // R19
    nxtState.kanjiMode  = (fonSel == PAC_FON_K8) || (fonSel == PAC_FON_K16); // R21

    // Reset: strap picks mode default, adjust bits cleared
    if (rst) begin
      nxtState          = '0;
      nxtState.st       = PAC_IDLE;
      nxtState.hsyncPrev = 1'b1;
      nxtState.hsyncOutN = 1'b1;
      nxtState.memReady  = 1'b1;
      nxtState.hadj     = PAC_HADJ_RST; // R23
      nxtState.ctrl     = PAC_CTRL_RST;
      nxtState.mode     = raster_addr_bit4_strap ? PAC_MODE_RST_HI : PAC_MODE_RST_LO; // R11
    end
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    stateFf <= nxtState;
  end

  assign prdata           = stateFf.prdata;
  assign pready           = stateFf.pready;
  assign pslverr          = stateFf.pslverr;
  assign panel_line_latch = stateFf.lineLatch;
  assign panelHsyncN      = stateFf.hsyncOutN;
  assign charFetch        = stateFf.charFetch;
  assign cpu_memory_ready = stateFf.memReady;
  assign cpuAccessGo      = stateFf.accessGo;
  assign cursorVisible    = stateFf.cursorVisible;
  assign pixFg            = stateFf.pixFg;
  assign pixBg            = stateFf.pixBg;
  assign underlineOn      = stateFf.underlineOn;
  assign bankBase         = stateFf.bankBase;
  assign bytesPerFetch    = stateFf.bytesPerFetch;
  assign bitsPerPixel     = stateFf.bitsPerPixel;
  assign glyphWidth       = stateFf.glyphWidth;
  assign kanjiMode        = stateFf.kanjiMode;

  // Checks
  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_adjust_latch;
    (stateFf.st == PAC_DELAY && stateFf.delayCnt == 10'd0 && !stateFf.ctrl[PAC_CTRL_ELP])
      |=> panel_line_latch && panelHsyncN;
  endproperty
  a_adjust_latch: assert property (p_adjust_latch) else $error("line latch missing after adjust"); // R3

  property p_adjust_hsync;
    (stateFf.st == PAC_DELAY && stateFf.delayCnt == 10'd0 && stateFf.ctrl[PAC_CTRL_ELP])
      |=> !panelHsyncN && !panel_line_latch;
  endproperty
  a_adjust_hsync: assert property (p_adjust_hsync) else $error("panel hsync missing after adjust"); // R3

  property p_adjust_load;
    (stateFf.st == PAC_IDLE && hsyncRise)
      |=> stateFf.delayCnt == 10'($past(adjUnits) * $past(unitNow)) - 10'd1;
  endproperty
  a_adjust_load: assert property (p_adjust_load) else $error("adjust count wrong"); // R1

  property p_unit;
    (stateFf.ctrl[PAC_CTRL_GFX] || stateFf.kanjiMode) |-> unitNow == PAC_KANJI_UNIT;
  endproperty
  a_unit: assert property (p_unit) else $error("adjust unit not eight"); // R2

  property p_wait;
    (cpuMemReq && !cpu_memory_ready && !slotHit) |=> !cpu_memory_ready || !$past(cpuMemReq);
  endproperty
  a_wait: assert property (p_wait) else $error("wait released without slot"); // R8

  property p_fast;
    (cpuMemReq && !cpu_memory_ready && cpuSlotFast && stateFf.hadj[PAC_HADJ_SCT])
      |=> cpu_memory_ready && cpuAccessGo;
  endproperty
  a_fast: assert property (p_fast) else $error("fast slot not used"); // R9

  property p_slow_blink;
    (stateFf.hadj[PAC_HADJ_SCU] && stateFf.fieldCnt[4:3] != 2'b00) |=> !cursorVisible;
  endproperty
  a_slow_blink: assert property (p_slow_blink) else $error("slow blink on too long"); // R10

  property p_mono;
    (stateFf.mode[PAC_MODE_MON] && attrFg[2:0] == 3'h1 && attrBg[2:0] == 3'h2)
      |=> pixFg[2:0] == 3'h7 && pixBg[2:0] == 3'h0 && pixFg[3] == $past(attrFg[3]);
  endproperty
  a_mono: assert property (p_mono) else $error("single-tone map wrong"); // R12 R13

  property p_underline_white;
    (!stateFf.mode[PAC_MODE_MON] && ulShow) |=> underlineOn && pixFg[2:0] == 3'h7;
  endproperty
  a_underline_white: assert property (p_underline_white) else $error("underline colour wrong"); // R14 R15

  property p_bank4;
    (grmSel[2] && raster_addr_bit1 && raster_addr_bit0) |=> bankBase == 15'h6000;
  endproperty
  a_bank4: assert property (p_bank4) else $error("fourth bank base wrong"); // R18

  property p_reset_mode;
    @(posedge clk_sys) disable iff (1'b0)
    (rst && raster_addr_bit4_strap) |=> stateFf.mode == PAC_MODE_RST_HI && stateFf.hadj[7:6] == 2'b00;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset mode value wrong"); // R11 R23

  c_latch: cover property (panel_line_latch);
  c_fetch: cover property (charFetch && kanjiMode);
  c_wait:  cover property (!cpu_memory_ready ##[1:20] cpuAccessGo);
  c_ul:    cover property (underlineOn);
endmodule : pac_adjust_mode

/* File: bench/pac_panel_model.sv */
// Purpose: Panel-side model giving line sync and measuring each line start
// Assumes: One pixel per clk_sys cycle
// Notes:   lineRes = {kind, cycles from seen sync rise, first fetch gap}
`timescale 1ns/10ps
module pac_panel_model (
  input  wire logic        clk_sys,
  input  wire logic        lineGo,
  input  wire logic        panel_line_latch,
  input  wire logic        panelHsyncN,
  input  wire logic        charFetch,
  output logic             hsyncN,
  output logic             displayEn,
  output logic             lineDone,
  output logic [25:0]      lineRes
);
  logic [15:0] cnt;
  logic [15:0] refCnt;
  logic        hsPrev;
  logic [7:0]  fcnt;
  logic [3:0]  nf;

  initial begin
    hsyncN = 1'b1;
    displayEn = 1'b0;
    lineDone = 1'b0;
    cnt = 16'h2F9;
  end

  // One line per request; long enough for the widest adjust plus sync
  always @(posedge clk_sys) begin
    hsPrev <= hsyncN;
    lineDone <= (cnt == 16'h2F8);
    displayEn <= (cnt >= 16'h8 && cnt < 16'h2F8);
    refCnt <= (hsyncN && !hsPrev) ? 16'h0 : refCnt + 16'h1;
    fcnt <= (charFetch === 1'b1) ? 8'h1 : fcnt + 8'h1;
    if (cnt == 16'h7) hsyncN <= 1'b1;
    if (lineGo) begin
      cnt <= 16'h0;
      hsyncN <= 1'b0;
      nf <= 4'h0;
      lineRes <= 26'h0;
    end else begin
      if (cnt < 16'h2F9) cnt <= cnt + 16'h1;
      if (panel_line_latch === 1'b1) lineRes[25:8] <= {2'b01, refCnt};
      if (panelHsyncN === 1'b0) lineRes[25:8] <= {2'b10, refCnt};
      if (charFetch === 1'b1) begin
        nf <= nf + 4'h1;
        if (nf == 4'h1) lineRes[7:0] <= fcnt;
      end
    end
  end
endmodule : pac_panel_model

/* File: bench/pac_adjust_mode_tb.sv */
// Purpose: Self-checking bench of the panel adjust and display mode block
// Assumes: Expectations follow the registers as written over APB
// Notes:   Drivers queue expectations; one monitor compares them
`timescale 1ns/10ps
module pac_adjust_mode_tb;
  import pac_pkg::*;
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, raster_addr_bit4_strap = 1'b0, hsyncN, displayEn, cpuMemReq = 1'b0;
  logic        cpuSlotStd = 1'b0, cpuSlotFast = 1'b0, fieldStart = 1'b0, cursorBlinkCtrl = 1'b0;
  logic        underlineRow = 1'b0, raster_addr_bit0 = 1'b0, raster_addr_bit1 = 1'b0, lineGo = 1'b0;
  logic        panel_line_latch, panelHsyncN, charFetch, cpu_memory_ready, cpuAccessGo, cursorVisible;
  logic        underlineOn, kanjiMode, lineDone, lastFast = 1'b0, pixStb = 1'b0, pixStbD = 1'b0;
  logic [3:0]  attrFg = 4'h0, attrBg = 4'h0, pixFg, pixBg, bitsPerPixel;
  logic [14:0] bankBase;
  logic [2:0]  bytesPerFetch;
  logic [4:0]  glyphWidth;
  logic [25:0] lineRes;
  logic [7:0]  modeSh = 8'h02, ctrlSh = 8'h00;
  logic [33:0] e;
  logic [33:0] apbQ[$];
  logic [25:0] lineQ[$];
  logic [36:0] pixQ[$];
  logic        cpuQ[$];
  int          errCount = 0, checks = 0, cyc = 0, i, k;

  // System clock, 10 ns
  always #5 clk_sys = ~clk_sys;

  pac_adjust_mode uut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .raster_addr_bit4_strap, .hsyncN, .displayEn, .cpuMemReq, .cpuSlotStd, .cpuSlotFast, .fieldStart,
    .cursorBlinkCtrl, .attrFg, .attrBg, .underlineRow, .raster_addr_bit0, .raster_addr_bit1,
    .panel_line_latch, .panelHsyncN, .charFetch, .cpu_memory_ready, .cpuAccessGo, .cursorVisible,
    .pixFg, .pixBg, .underlineOn, .bankBase, .bytesPerFetch, .bitsPerPixel, .glyphWidth, .kanjiMode
  );
  pac_panel_model panel (
    .clk_sys, .lineGo, .panel_line_latch, .panelHsyncN, .charFetch, .hsyncN, .displayEn, .lineDone, .lineRes
  );

  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [4:0] gw(input logic [2:0] c);
    return (c < 3'h5) ? 5'h6 + {2'h0, c} : ((c == 3'h6) ? 5'h10 : 5'h8);
  endfunction : gw

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [7:0] x,
                     input logic er);
    apbQ.push_back({~wr, er, 24'h0, x});
    if (wr && a == PAC_ADDR_MODE) modeSh = d;
    if (wr && a == PAC_ADDR_CTRL) ctrlSh = d;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Attribute and raster stimulus; expectation from the shadow registers
  task automatic pix(input logic [3:0] f, input logic [3:0] b, input logic u, input logic [1:0] ra);
    logic [3:0] ef, eb, bpp;
    logic       eu;
    logic [1:0] dp;
    ef = f;
    eb = b;
    dp = modeSh[4:3];
    eu = modeSh[6] && f[2:0] == 3'h1 && u;
    if (modeSh[7] && !((b[2:0] == 3'h0 || b[2:0] == 3'h7) && f[2:0] == 3'h0)) begin
      ef[2:0] = 3'h7;
      eb[2:0] = 3'h0;
    end else if (!modeSh[7] && eu) ef[2:0] = 3'h7;
    bpp = ((dp == 2'h0) ? 4'h1 : (dp == 2'h2) ? 4'h4 : 4'h2) << ctrlSh[1];
    pixQ.push_back({ef, eb, eu, (modeSh[5] ? {ra, 13'h0} : {1'b0, ra[0], 13'h0}),
                    (dp == 2'h1) ? 3'h2 : (dp == 2'h2) ? 3'h4 : 3'h1, bpp, gw(modeSh[2:0]),
                    modeSh[2:0] == 3'h5 || modeSh[2:0] == 3'h6});
    attrFg <= f;
    attrBg <= b;
    underlineRow <= u;
    raster_addr_bit0 <= ra[0];
    raster_addr_bit1 <= ra[1];
    pixStb <= 1'b1;
    @(posedge clk_sys);
  endtask : pix

  // One panel line with the given mode and adjust units
  task automatic line(input logic elp, input logic gfx, input logic [2:0] font, input logic [5:0] u);
    logic [4:0]  w;
    logic [15:0] n;
    apb(1'b1, PAC_ADDR_CTRL, {5'h0, elp, 1'b0, gfx}, 8'h0, 1'b0);
    apb(1'b1, PAC_ADDR_MODE, {5'h0, font}, 8'h0, 1'b0);
    apb(1'b1, PAC_ADDR_HADJ, {2'h0, u}, 8'h0, 1'b0);
    w = (gfx || font == 3'h5 || font == 3'h6) ? 5'h8 : gw(font);
    n = ((u == 6'h0) ? 16'h40 : {10'h0, u}) * {11'h0, w};
    lineQ.push_back({elp ? 2'b10 : 2'b01, n, 3'h0, w});
    lineGo <= 1'b1;
    @(posedge clk_sys);
    lineGo <= 1'b0;
    repeat (770) @(posedge clk_sys);
  endtask : line

  // Video memory request; fast slot first, standard slot if still waiting
  task automatic cpu(input logic cpu_access_timing_sel);
    apb(1'b1, PAC_ADDR_HADJ, {cpu_access_timing_sel, 7'h0}, 8'h0, 1'b0);
    cpuQ.push_back(cpu_access_timing_sel);
    cpuMemReq <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp(cpu_memory_ready, 1'b0);
    cpuSlotFast <= 1'b1;
    lastFast <= 1'b1;
    @(posedge clk_sys);
    cpuSlotFast <= 1'b0;
    repeat (3) @(posedge clk_sys);
    if (cpu_memory_ready === 1'b0) begin
      cpuSlotStd <= 1'b1;
      lastFast <= 1'b0;
      @(posedge clk_sys);
      cpuSlotStd <= 1'b0;
    end
    while (cpu_memory_ready !== 1'b1) @(posedge clk_sys);
    cpuMemReq <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : cpu

  // Monitor: oldest note against each result as it shows; hang guard
  always @(posedge clk_sys) begin
    cyc++;
    pixStbD <= pixStb;
    if (psel && penable && pready === 1'b1) begin
      e = apbQ.pop_front();
      if (e[33]) cmp(prdata, e[31:0]);
      cmp(pslverr, e[32]);
    end
    if (lineDone === 1'b1) cmp(lineRes, lineQ.pop_front());
    if (pixStbD) cmp({pixFg, pixBg, underlineOn, bankBase, bytesPerFetch, bitsPerPixel, glyphWidth,
                      kanjiMode}, pixQ.pop_front());
    if (cpuAccessGo === 1'b1) cmp(lastFast, cpuQ.pop_front());
    if (cyc == 20000) begin
      errCount++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(13));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, PAC_ADDR_HADJ, 8'h0, 8'h00, 1'b0);
    apb(1'b0, PAC_ADDR_MODE, 8'h0, 8'h02, 1'b0);
    apb(1'b1, PAC_ADDR_HADJ, 8'hC5, 8'h0, 1'b0);
    apb(1'b0, PAC_ADDR_HADJ, 8'h0, 8'hC5, 1'b0);
    r = $urandom;
    apb(1'b1, PAC_ADDR_MODE, r[7:0], 8'h0, 1'b0);
    apb(1'b0, PAC_ADDR_MODE, 8'h0, r[7:0], 1'b0);
    apb(1'b1, 10'h3FC, 8'hFF, 8'h0, 1'b1);
    apb(1'b0, 10'h3FC, 8'h0, 8'h00, 1'b1);
    // Second reset with the strap high
    raster_addr_bit4_strap <= 1'b1;
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    modeSh = 8'hE3;
    ctrlSh = 8'h00;
    apb(1'b0, PAC_ADDR_HADJ, 8'h0, 8'h00, 1'b0);
    apb(1'b0, PAC_ADDR_MODE, 8'h0, 8'hE3, 1'b0);
    // Depth, bank and font decode sweep
    for (i = 0; i < 7; i++) begin
      r = $urandom;
      apb(1'b1, PAC_ADDR_CTRL, {6'h0, i[1], 1'b0}, 8'h0, 1'b0);
      apb(1'b1, PAC_ADDR_MODE, {2'h0, i[0], i[1], i > 4, i[2:0]}, 8'h0, 1'b0);
      pix(4'h0, 4'h0, 1'b0, r[1:0]);
      pixStb <= 1'b0;
    end
    // Single-tone map with underline, fixed corners then random pairs
    apb(1'b1, PAC_ADDR_CTRL, 8'h0, 8'h0, 1'b0);
    apb(1'b1, PAC_ADDR_MODE, 8'hC2, 8'h0, 1'b0);
    pix(4'h8, 4'h0, 1'b0, 2'h0);
    pix(4'h0, 4'hF, 1'b0, 2'h1);
    pix(4'h9, 4'hA, 1'b1, 2'h2);
    repeat (24) begin
      r = $urandom;
      pix(r[3:0], r[7:4], r[8], r[10:9]);
    end
    pixStb <= 1'b0;
    apb(1'b1, PAC_ADDR_MODE, 8'h62, 8'h0, 1'b0);
    pix(4'h1, 4'h2, 1'b1, 2'h0);
    pix(4'h9, 4'h0, 1'b1, 2'h3);
    pix(4'h6, 4'h1, 1'b1, 2'h0);
    pixStb <= 1'b0;
    // Line start delay per mode
    line(1'b0, 1'b1, 3'h2, 6'h01);
    line(1'b0, 1'b1, 3'h2, 6'h00);
    line(1'b0, 1'b0, 3'h0, 6'h03);
    line(1'b0, 1'b0, 3'h4, 6'h05);
    line(1'b0, 1'b0, 3'h5, 6'h02);
    line(1'b1, 1'b1, 3'h2, 6'h04);
    cpu(1'b0);
    cpu(1'b1);
    // Slow blink over 32 fields
    apb(1'b1, PAC_ADDR_HADJ, 8'h40, 8'h0, 1'b0);
    k = 0;
    repeat (32) begin
      fieldStart <= 1'b1;
      @(posedge clk_sys);
      fieldStart <= 1'b0;
      repeat (3) @(posedge clk_sys);
      k += (cursorVisible === 1'b1);
    end
    cmp(k, 48'h8);
    complete_run();
  end
endmodule : pac_adjust_mode_tb
